// ---- core/acp_serial_port.sv ----
// Serial configuration and result port of a 12-bit sampling converter.
// Assumes the analog core starts on CONV_START_O and pulses CONV_DONE_I
// with its raw code (straight binary unipolar, offset binary bipolar).
`timescale 1ns/1ns
module acp_serial_port (
  input  wire logic       REF_CLK_I,
  input  wire logic       SRST_I,
  input  wire logic       CS_N_I,
  input  wire logic       SCLK_I,
  input  wire logic       DIN_I,
  input  wire logic       ACLK_I,
  input  wire logic [11:0] RESULT_I,
  input  wire logic       CONV_DONE_I,
  output logic            DOUT_O,
  output logic            DOUT_OE_N_O,
  output logic            CONV_START_O,
  output logic            SHUTDOWN_O,
  output logic            SINGLE_ENDED_SELECT_O,
  output logic            ODD_CHANNEL_O,
  output logic [1:0]      PAIR_SELECT_O,
  output logic            POLARITY_SELECT_O
);

  // ************************************************************
  // Pin synchronisers and deglitcher
  // ************************************************************
  logic [2:0] sclk_q;
  logic [2:0] aclk_q;
  logic [1:0] cs_q;
  logic [1:0] din_q;
  logic       cs_act_q, cs_act_d;
  logic       cs_prev_q;
  logic [1:0] glitch_q, glitch_d;
  logic       aclk_fall;
  logic       sclk_rise;
  logic       sclk_fall;

  assign aclk_fall = aclk_q[2] & ~aclk_q[1];
  assign sclk_rise = ~sclk_q[2] & sclk_q[1];
  assign sclk_fall = sclk_q[2] & ~sclk_q[1];

  // The count restarts whenever the pin agrees with the accepted level,
  // so a pulse that spans only one conversion clock fall is never taken.
  always_comb begin
    cs_act_d = cs_act_q;
    glitch_d = 2'h0;
    if (cs_q[1] != cs_act_q) begin
      glitch_d = glitch_q;
      if (aclk_fall) begin
        if (glitch_q == acp_pkg::DEGLITCH_LAST) begin
          cs_act_d = cs_q[1];
          glitch_d = 2'h0;
        end else begin
          glitch_d = glitch_q + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      sclk_q    <= 3'h0;
      aclk_q    <= 3'h0;
      cs_q      <= 2'h0;
      din_q     <= 2'h0;
      cs_act_q  <= 1'b0;
      cs_prev_q <= 1'b0;
      glitch_q  <= 2'h0;
    end else begin
      sclk_q    <= {sclk_q[1:0], SCLK_I};
      aclk_q    <= {aclk_q[1:0], ACLK_I};
      cs_q      <= {cs_q[0], ~CS_N_I};
      din_q     <= {din_q[0], DIN_I};
      cs_act_q  <= cs_act_d;
      cs_prev_q <= cs_act_q;
      glitch_q  <= glitch_d;
    end
  end

  // ************************************************************
  // Transfer state machine
  // ************************************************************
  acp_pkg::acp_state_e state_q, state_d;
  logic [4:0]  bit_q, bit_d;
  logic [4:0]  rise_q, rise_d;
  logic [7:0]  shift_q, shift_d;
  logic [7:0]  cfg_q, cfg_d;
  logic [11:0] res_q, res_d;
  logic        msb_first_select_q, msb_first_select_d;
  logic        start_q, start_d;
  logic        dout_q, dout_d;
  logic        oe_n_q, oe_n_d;
  logic        shdn_q, shdn_d;
  logic [7:0]  word;
  logic        xfer_end;

  function automatic logic [4:0] len_of(input logic [1:0] code);
    case (code)
      acp_pkg::LEN_CODE_8:  len_of = acp_pkg::LEN_8;
      acp_pkg::LEN_CODE_12: len_of = acp_pkg::LEN_12;
      acp_pkg::LEN_CODE_16: len_of = acp_pkg::LEN_16;
      default:              len_of = acp_pkg::LEN_10;
    endcase
  endfunction : len_of

  // Positions past the result read as zero, which pads 16-bit words.
  function automatic logic out_bit(input logic [11:0] res,
                                   input logic msb_first_select,
                                   input logic [4:0] idx);
    logic [3:0] k;
    k = idx[3:0];
    if (idx >= 5'(acp_pkg::RES_W)) begin
      out_bit = 1'b0;
    end else if (msb_first_select) begin
      out_bit = res[acp_pkg::RES_MSB - k];
    end else begin
      out_bit = res[k];
    end
  endfunction : out_bit

  // Input bits always fill from the top, whatever the output order.
  assign word = (rise_q < acp_pkg::CFG_BITS) ?
                {shift_q[6:0], din_q[1]} : shift_q;
  assign xfer_end = sclk_rise &&
                    (rise_q + 5'h01 == len_of(word[1:0]));

  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    rise_d  = rise_q;
    shift_d = shift_q;
    cfg_d   = cfg_q;
    res_d   = res_q;
    msb_first_select_d  = msb_first_select_q;
    start_d = 1'b0;
    case (state_q)
      acp_pkg::ST_IDLE: begin
        if (cs_act_q) begin
          state_d = acp_pkg::ST_XFER;
          bit_d   = 5'h00;
          rise_d  = 5'h00;
        end
      end
      acp_pkg::ST_XFER: begin
        if (!cs_act_q) begin
          state_d = acp_pkg::ST_IDLE;
        end else begin
          if (sclk_fall && bit_q != acp_pkg::BIT_LAST) begin
            bit_d = bit_q + 5'h01;
          end
          if (sclk_rise) begin
            rise_d  = rise_q + 5'h01;
            shift_d = word;
          end
          if (xfer_end) begin
            cfg_d = word;
            if (word[1:0] == acp_pkg::LEN_CODE_SHDN) begin
              state_d = acp_pkg::ST_SHDN;
            end else begin
              state_d = acp_pkg::ST_CONV;
              start_d = 1'b1;
            end
          end
        end
      end
      acp_pkg::ST_CONV: begin
        if (CONV_DONE_I) begin
          // Bipolar core code is offset binary; flipping the top bit
          // yields two's complement without an adder.
          res_d = {RESULT_I[11] ^ ~cfg_q[acp_pkg::CFG_POL],
                   RESULT_I[10:0]};
          msb_first_select_d  = cfg_q[acp_pkg::CFG_MSB_FIRST_SELECT];
          bit_d   = 5'h00;
          rise_d  = 5'h00;
          state_d = cs_act_q ? acp_pkg::ST_XFER : acp_pkg::ST_IDLE;
        end
      end
      acp_pkg::ST_SHDN: begin
        if ((cs_act_q && !cs_prev_q) ||
            (cs_act_q && (sclk_rise || sclk_fall))) begin
          state_d = acp_pkg::ST_XFER;
          bit_d   = 5'h00;
          rise_d  = 5'h00;
        end
      end
      default: state_d = acp_pkg::ST_IDLE;
    endcase
    dout_d = out_bit(res_d, msb_first_select_d, bit_d);
    oe_n_d = (state_d != acp_pkg::ST_XFER);
    shdn_d = (state_d == acp_pkg::ST_SHDN);
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      state_q <= acp_pkg::ST_IDLE;
      bit_q   <= 5'h00;
      rise_q  <= 5'h00;
      shift_q <= acp_pkg::CFG_RST;
      cfg_q   <= acp_pkg::CFG_RST;
      res_q   <= acp_pkg::RES_RST;
      msb_first_select_q  <= 1'b0;
      start_q <= 1'b0;
      dout_q  <= 1'b0;
      oe_n_q  <= 1'b1;
      shdn_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_q   <= bit_d;
      rise_q  <= rise_d;
      shift_q <= shift_d;
      cfg_q   <= cfg_d;
      res_q   <= res_d;
      msb_first_select_q  <= msb_first_select_d;
      start_q <= start_d;
      dout_q  <= dout_d;
      oe_n_q  <= oe_n_d;
      shdn_q  <= shdn_d;
    end
  end

  assign DOUT_O                = dout_q;
  assign DOUT_OE_N_O           = oe_n_q;
  assign CONV_START_O          = start_q;
  assign SHUTDOWN_O            = shdn_q;
  assign SINGLE_ENDED_SELECT_O = cfg_q[acp_pkg::CFG_SINGLE];
  assign ODD_CHANNEL_O         = cfg_q[acp_pkg::CFG_ODD];
  assign PAIR_SELECT_O = cfg_q[acp_pkg::CFG_SEL_HI:acp_pkg::CFG_SEL_LO];
  assign POLARITY_SELECT_O     = cfg_q[acp_pkg::CFG_POL];

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);

  a_hiz_released: assert property (
    !cs_act_q |=> DOUT_OE_N_O)
    else $error("result driven while chip select released");
  a_deglitch_two: assert property (
    $changed(cs_act_q) |-> $past(aclk_fall && glitch_q == 2'h1))
    else $error("chip select taken without two clock falls");
  a_start_cfg: assert property (
    CONV_START_O |-> $past(xfer_end) &&
      cfg_q[1:0] != acp_pkg::LEN_CODE_SHDN && state_q == acp_pkg::ST_CONV)
    else $error("conversion start without latched word");
  a_shdn_enter: assert property (
    state_q == acp_pkg::ST_XFER && cs_act_q && xfer_end &&
      word[1:0] == acp_pkg::LEN_CODE_SHDN |=> SHUTDOWN_O && !CONV_START_O)
    else $error("shutdown word did not power down");
  a_len_end: assert property (
    state_q == acp_pkg::ST_XFER && $past(state_q) == acp_pkg::ST_XFER &&
      cs_act_q && sclk_rise && rise_q == 5'h07 && word[1:0] == 2'h0
      |=> state_q != acp_pkg::ST_XFER)
    else $error("8-bit transfer did not end on eighth edge");
  a_zero_tail: assert property (
    !DOUT_OE_N_O && bit_q >= 5'h0C |-> !DOUT_O)
    else $error("padding bit not zero");
  a_bipolar_sign: assert property (
    state_q == acp_pkg::ST_CONV && CONV_DONE_I &&
      !cfg_q[acp_pkg::CFG_POL] |=> res_q[11] == ~$past(RESULT_I[11]))
    else $error("bipolar sign not formed");
  a_first_bit: assert property (
    state_q == acp_pkg::ST_CONV && CONV_DONE_I && cs_act_q |=>
      !DOUT_OE_N_O && bit_q == 5'h00 &&
      DOUT_O == (msb_first_select_q ? res_q[11] : res_q[0]))
    else $error("first bit not presented after conversion");

endmodule : acp_serial_port

// ---- core/acp_pkg.sv ----
// Constants and types shared by the converter serial configuration port.
// Assumes a single system clock; all pin timing is sampled on that clock.
package acp_pkg;

  // ************************************************************
  // Word sizes
  // ************************************************************
  localparam int CFG_W = 8;
  localparam int RES_W = 12;
  localparam int CNT_W = 5;
  localparam logic [3:0] RES_MSB = 4'hB;

  // ************************************************************
  // Configuration word bit positions (first bit received is 7)
  // ************************************************************
  localparam int CFG_SINGLE = 7;
  localparam int CFG_ODD    = 6;
  localparam int CFG_SEL_HI = 5;
  localparam int CFG_SEL_LO = 4;
  localparam int CFG_POL    = 3;
  localparam int CFG_MSB_FIRST_SELECT   = 2;
  localparam int CFG_LEN_HI = 1;
  localparam int CFG_LEN_LO = 0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [11:0] RES_RST = 12'h000;

  // ************************************************************
  // Length codes and output word lengths
  // ************************************************************
  localparam logic [1:0] LEN_CODE_8    = 2'h0;
  localparam logic [1:0] LEN_CODE_SHDN = 2'h1;
  localparam logic [1:0] LEN_CODE_12   = 2'h2;
  localparam logic [1:0] LEN_CODE_16   = 2'h3;
  localparam logic [4:0] LEN_8  = 5'h08;
  localparam logic [4:0] LEN_10 = 5'h0A;
  localparam logic [4:0] LEN_12 = 5'h0C;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] CFG_BITS = 5'h08;
  localparam logic [4:0] BIT_LAST = 5'h0F;

  // ************************************************************
  // Deglitcher: a change is taken on its second conversion clock fall
  // ************************************************************
  localparam logic [1:0] DEGLITCH_LAST = 2'h1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_XFER,
    ST_CONV,
    ST_SHDN
  } acp_state_e;

endpackage : acp_pkg

// ---- tb/acp_host_model.sv ----
// Host side of the serial link: chip select, shift clock and config data.
// Assumes the 250 MHz bench clock; one shift clock is 20 cycles (80 ns).
`timescale 1ns/1ns
module acp_host_model (
  input  wire logic clk_i,
  input  wire logic dout_i,
  input  wire logic dout_oe_n_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      din_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o  = 1'b0;
  end

  // ************************************************************
  // One exchange; keep leaves chip select low through the conversion
  // ************************************************************
  task automatic xfer(input logic [7:0] cfg, input int len, input bit keep,
                      output logic [15:0] got, output bit ok);
    int n;
    got = 16'h0000;
    n = 0;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    while (dout_oe_n_i !== 1'b0 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    ok = (n < 200);
    for (int i = 0; i < len; i++) begin
      sclk_o = 1'b0;
      din_o = (i < 8) ? cfg[7 - i] : ~din_o;
      repeat (10) @(negedge clk_i);
      got[i] = dout_i;
      sclk_o = 1'b1;
      repeat (10) @(negedge clk_i);
    end
    // In keep mode the closing fall comes at once, so a shutdown word
    // wakes on it; otherwise chip select is released before that fall.
    if (keep) sclk_o = 1'b0;
    else cs_n_o = 1'b1;
    repeat (40) @(negedge clk_i);
    sclk_o = 1'b0;
    repeat (40) @(negedge clk_i);
  endtask : xfer

  task automatic glitch();
    @(negedge clk_i);
    cs_n_o = 1'b0;
    sclk_o = 1'b1;
    repeat (2) @(negedge clk_i);
    cs_n_o = 1'b1;
    repeat (10) @(negedge clk_i);
    sclk_o = 1'b0;
  endtask : glitch
endmodule : acp_host_model

// ---- tb/testbench.sv ----
// Self-checking bench for the converter serial port.
// Assumes the host model above and a behavioural analog core below.
`timescale 1ns/1ns
module testbench;
  logic        clk;
  logic        srst;
  logic        aclk;
  logic        done;
  logic [11:0] raw;
  logic [11:0] next_raw;
  logic        cs_n, sclk, din, dout, oe_n, start, shdn, sgl, odd, pol;
  logic [1:0]  pair;
  wire         dout_pin = oe_n ? 1'bz : dout;
  int          bad_count, checks, starts;

  initial begin clk = 1'b0; forever #2 clk = ~clk; end
  initial begin aclk = 1'b0; #3; forever #20 aclk = ~aclk; end

  acp_serial_port i_acp_serial_port (.REF_CLK_I(clk), .SRST_I(srst),
    .CS_N_I(cs_n), .SCLK_I(sclk), .DIN_I(din), .ACLK_I(aclk),
    .RESULT_I(raw), .CONV_DONE_I(done), .DOUT_O(dout), .DOUT_OE_N_O(oe_n),
    .CONV_START_O(start), .SHUTDOWN_O(shdn), .SINGLE_ENDED_SELECT_O(sgl),
    .ODD_CHANNEL_O(odd), .PAIR_SELECT_O(pair), .POLARITY_SELECT_O(pol));

  acp_host_model i_acp_host_model (.clk_i(clk), .dout_i(dout_pin),
    .dout_oe_n_i(oe_n), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));

  // ************************************************************
  // Analog core: answers every start 20 cycles later
  // ************************************************************
  always @(posedge clk) if (start === 1'b1) starts <= starts + 1;
  initial begin
    done = 1'b0;
    raw = 12'h000;
    forever begin
      @(posedge clk iff start === 1'b1);
      repeat (20) @(negedge clk);
      raw = next_raw;
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
    end
  end

  // ************************************************************
  // Checking helpers
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [15:0] fmt(input logic [11:0] r, input logic polarity_select,
                                      input logic msb_first_select, input int len);
    logic [11:0] w;
    fmt = 16'h0000;
    w = polarity_select ? r : {~r[11], r[10:0]};
    for (int i = 0; i < len; i++)
      if (i < 12) fmt[i] = msb_first_select ? w[11 - i] : w[i];
  endfunction : fmt

  task automatic exch(input logic [7:0] cfg, input int len, input bit keep,
                      input logic [15:0] exp, input logic [11:0] nr);
    logic [15:0] got;
    bit          ok;
    next_raw = nr;
    i_acp_host_model.xfer(cfg, len, keep, got, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(got, exp);
  endtask : exch

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_glitch();
    int hits;
    hits = 0;
    fork
      i_acp_host_model.glitch();
      repeat (60) begin
        @(negedge clk);
        if (oe_n !== 1'b1) hits++;
      end
    join
    chk(16'(hits), 16'h0000);
  endtask : t_glitch

  task automatic t_formats();
    exch(8'hAE, 12, 0, 16'h0000, 12'hA53);
    exch(8'h53, 16, 0, fmt(12'hA53, 1, 1, 16), 12'h123);
    exch(8'hFC, 8, 0, fmt(12'h123, 0, 0, 8), 12'h7FF);
    chk({11'h000, sgl, odd, pair, pol}, 16'h001F);
    chk(16'(starts), 16'h0003);
  endtask : t_formats

  task automatic t_cs_low();
    exch(8'hAC, 8, 1, fmt(12'h7FF, 1, 1, 8), 12'h5A5);
    exch(8'hAE, 12, 0, fmt(12'h5A5, 1, 1, 12), 12'h0F0);
  endtask : t_cs_low

  task automatic t_shutdown();
    exch(8'h0D, 10, 0, fmt(12'h0F0, 1, 1, 10), 12'h0F0);
    chk({15'h0000, shdn}, 16'h0001);
    chk(16'(starts), 16'h0005);
    exch(8'hAE, 12, 0, fmt(12'h0F0, 1, 1, 12), 12'h0F0);
    chk({15'h0000, shdn}, 16'h0000);
    chk(16'(starts), 16'h0006);
    exch(8'h0D, 10, 1, fmt(12'h0F0, 1, 1, 10), 12'h0F0);
    chk({14'h0000, shdn, oe_n}, 16'h0000);
    exch(8'hAE, 12, 0, fmt(12'h0F0, 1, 1, 12), 12'h0F0);
    chk(16'(starts), 16'h0007);
  endtask : t_shutdown

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end

  initial begin
    srst = 1'b1;
    next_raw = 12'h000;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (5) @(negedge clk);
    t_glitch();
    t_formats();
    t_cs_low();
    t_shutdown();
    give_verdict();
  end
endmodule : testbench
